// ==== uart_mp_consts.svh ====
// offsets, field positions, reset values and timing counts of the serial port
`ifndef UART_MP_CONSTS_SVH
`define UART_MP_CONSTS_SVH

// register byte addresses
`define OFS_SERIAL_CONTROL   12'h098
`define OFS_SERIAL_DATA      12'h09C
`define OFS_POWER_CONTROL    12'h080
`define OFS_BAUD_RELOAD      12'h090
`define OFS_IRQ_ENABLE_REG   12'h0A0
`define OFS_SLAVE_ADDR       12'h0A8
`define OFS_SLAVE_MASK       12'h0B8

// serial_control bit positions
`define SC_MODE0_FE          7
`define SC_MODE1             6
`define SC_MULTIPROC         5
`define SC_RX_ENABLE         4
`define SC_TX_NINTH          3
`define SC_RX_NINTH          2
`define SC_TX_DONE           1
`define SC_RX_DONE           0

// power_control and irq_enable_reg bit positions
`define PC_BAUD_DOUBLER      7
`define PC_FRAMING_DETECT    6
`define IE_GLOBAL            7
`define IE_UART              4

// reset values
`define RST_SERIAL_CONTROL   8'h00
`define RST_ADDR_MASK        8'h00
`define RST_BYTE             8'h00

// bit timing in oversample ticks
`define TICKS_ASYNC_LAST     4'hF
`define TICKS_ASYNC_SAMPLE   4'h7
`define TICKS_SHIFT_LAST     4'h5
`define TICKS_SHIFT_SAMPLE   4'h2
`define RELOAD_TOP           10'h100

`endif

// ==== uart_mp_pkg.sv ====
// types shared by the serial port
package uart_mp_pkg;
  typedef enum logic [1:0] {
    LINE_IDLE = 2'b01,
    LINE_BUSY = 2'b10
  } line_state_e;

  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_8BIT  = 2'b01,
    MODE_9FIX  = 2'b10,
    MODE_9VAR  = 2'b11
  } port_mode_e;
endpackage : uart_mp_pkg

// ==== uart_multiproc_address_recog.sv ====
// serial port with ninth-bit multiprocessor address recognition, apb slave
// Notes on behaviour
// - fixed nine-bit mode runs clock/16 or clock/32
// - multiproc on: ninth bit zero frames dropped
// - ninth bit one: address match sets flags
// - eight-bit mode: stop bit acts as ninth
// - shift mode ignores multiproc enable bit
// - given address: mask zeros are don't care
// - broadcast address: address OR mask, zeros ignored
// - address and mask reset to zero
// - done flags merged; software clears them
// - irq needs uart and global enables
// - bit 7 framing error or mode bit
// - bit 5 enables multiproc and recognition
// - bit 4 gates reception
// - bit 3 sent as ninth bit
// - bit 2 holds received stop/ninth bit
// - bit 1 set after last data bit
// - bit 0 set at end of reception
// - receive flag on ninth or stop bit
// - control register resets to zero
// - framing detect moves receive flag to stop
// - framing error sticky until software clears
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "uart_mp_consts.svh"

module uart_multiproc_address_recog
  import uart_mp_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // serial line
  input  wire logic        rxd_in,
  output logic             rxd_out,
  output logic             rxd_oe_out,
  output logic             txd_out,
  // interrupt request to core
  output logic             irq_out
);

  // register state
  logic        port_mode_bit0_q, port_mode_bit1_q, multiproc_enable_q, ren_q, tx_ninth_bit_q, rx_ninth_bit_q;
  logic        tx_done_flag_q, rx_done_flag_q, framing_error_flag_q;
  logic        baud_doubler_q, framing_detect_enable_q, global_irq_enable_q, uart_irq_enable_q;
  logic [7:0]  slave_individual_address_q, slave_address_mask_q, reload_q, rx_data_q;
  logic [31:0] prdata_q;
  port_mode_e  mode;

  // bus decode, prescaler and shared timing
  logic        acc_w, setup_r, wr_serial_control, wr_data, mapped, os_tick, is_shift;
  logic [9:0]  div_cnt_q, div_max;
  logic [3:0]  tick_last, tick_sample;

  // receiver
  line_state_e rx_state_q;
  logic        rxd_m_q, rxd_s_q, rxd_p_q, rx_ninth_q, rx_sample, rx_eval, rx_accept, rx_fe_set, rx_last;
  logic [3:0]  rx_cnt_q, rx_bit_q, rx_stop_idx, rx_eval_idx;
  logic [7:0]  rx_sh_q, rx_byte, bcast;
  logic        rx_ninth, mp_active, given_hit, bcast_hit;

  // transmitter
  line_state_e tx_state_q;
  logic [3:0]  tx_cnt_q, tx_bit_q, tx_last_idx, tx_done_idx;
  logic [10:0] tx_sh_q;
  logic        tx_end_bit, tx_set;

  assign mode        = port_mode_e'({port_mode_bit0_q, port_mode_bit1_q});
  assign is_shift    = (mode == MODE_SHIFT);
  assign tick_last   = is_shift ? `TICKS_SHIFT_LAST : `TICKS_ASYNC_LAST;
  assign tick_sample = is_shift ? `TICKS_SHIFT_SAMPLE : `TICKS_ASYNC_SAMPLE;

  // apb setup-phase read and access-phase write strobes; pready is always high so no wait states
  assign acc_w   = psel_in & penable_in & pwrite_in;
  assign setup_r = psel_in & ~penable_in & ~pwrite_in;
  assign wr_serial_control = acc_w & (paddr_in == `OFS_SERIAL_CONTROL);
  assign wr_data = acc_w & (paddr_in == `OFS_SERIAL_DATA);

  // address map check
  always_comb begin
    if (paddr_in == `OFS_SERIAL_CONTROL || paddr_in == `OFS_SERIAL_DATA || paddr_in == `OFS_POWER_CONTROL ||
        paddr_in == `OFS_BAUD_RELOAD || paddr_in == `OFS_IRQ_ENABLE_REG || paddr_in == `OFS_SLAVE_ADDR ||
        paddr_in == `OFS_SLAVE_MASK) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~mapped;
  assign prdata_out  = prdata_q;

  // read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_r) begin
      if (paddr_in == `OFS_SERIAL_CONTROL) begin
        prdata_q <= {24'h00_0000, framing_detect_enable_q ? framing_error_flag_q : port_mode_bit0_q, port_mode_bit1_q,
                     multiproc_enable_q, ren_q, tx_ninth_bit_q, rx_ninth_bit_q, tx_done_flag_q, rx_done_flag_q};
      end else if (paddr_in == `OFS_SERIAL_DATA) begin
        prdata_q <= {24'h00_0000, rx_data_q};
      end else if (paddr_in == `OFS_POWER_CONTROL) begin
        prdata_q <= {24'h00_0000, baud_doubler_q, framing_detect_enable_q, 6'h00};
      end else if (paddr_in == `OFS_BAUD_RELOAD) begin
        prdata_q <= {24'h00_0000, reload_q};
      end else if (paddr_in == `OFS_IRQ_ENABLE_REG) begin
        prdata_q <= {24'h00_0000, global_irq_enable_q, 2'h0, uart_irq_enable_q, 4'h0};
      end else if (paddr_in == `OFS_SLAVE_ADDR) begin
        prdata_q <= {24'h00_0000, slave_individual_address_q};
      end else if (paddr_in == `OFS_SLAVE_MASK) begin
        prdata_q <= {24'h00_0000, slave_address_mask_q};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // serial control: software fields; bit 7 target depends on framing detect
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      {port_mode_bit0_q, port_mode_bit1_q, multiproc_enable_q, ren_q, tx_ninth_bit_q} <=
        5'(`RST_SERIAL_CONTROL >> 3);
    end else if (wr_serial_control) begin
      port_mode_bit0_q   <= framing_detect_enable_q ? port_mode_bit0_q : pwdata_in[`SC_MODE0_FE];
      port_mode_bit1_q   <= pwdata_in[`SC_MODE1];
      multiproc_enable_q <= pwdata_in[`SC_MULTIPROC];
      ren_q              <= pwdata_in[`SC_RX_ENABLE];
      tx_ninth_bit_q     <= pwdata_in[`SC_TX_NINTH];
    end
  end

  // hardware-set flags; a set in the same cycle as a write wins
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      rx_done_flag_q       <= 1'b0;
      tx_done_flag_q       <= 1'b0;
      rx_ninth_bit_q       <= 1'b0;
      framing_error_flag_q <= 1'b0;
    end else begin
      rx_done_flag_q <= rx_accept | (wr_serial_control ? pwdata_in[`SC_RX_DONE] : rx_done_flag_q);
      tx_done_flag_q <= tx_set | (wr_serial_control ? pwdata_in[`SC_TX_DONE] : tx_done_flag_q);
      framing_error_flag_q <= rx_fe_set |
        ((wr_serial_control && framing_detect_enable_q) ? pwdata_in[`SC_MODE0_FE] : framing_error_flag_q);
      if (rx_accept && !is_shift) begin
        rx_ninth_bit_q <= rx_ninth;
      end else if (wr_serial_control) begin
        rx_ninth_bit_q <= pwdata_in[`SC_RX_NINTH];
      end
    end
  end

  // power control, reload, irq enables and slave addressing
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      baud_doubler_q             <= 1'b0;
      framing_detect_enable_q    <= 1'b0;
      global_irq_enable_q        <= 1'b0;
      uart_irq_enable_q          <= 1'b0;
      reload_q                   <= `RST_BYTE;
      slave_individual_address_q <= `RST_ADDR_MASK;
      slave_address_mask_q       <= `RST_ADDR_MASK;
    end else if (acc_w) begin
      if (paddr_in == `OFS_POWER_CONTROL) begin
        baud_doubler_q          <= pwdata_in[`PC_BAUD_DOUBLER];
        framing_detect_enable_q <= pwdata_in[`PC_FRAMING_DETECT];
      end else if (paddr_in == `OFS_BAUD_RELOAD) begin
        reload_q <= pwdata_in[7:0];
      end else if (paddr_in == `OFS_IRQ_ENABLE_REG) begin
        global_irq_enable_q <= pwdata_in[`IE_GLOBAL];
        uart_irq_enable_q   <= pwdata_in[`IE_UART];
      end else if (paddr_in == `OFS_SLAVE_ADDR) begin
        slave_individual_address_q <= pwdata_in[7:0];
      end else if (paddr_in == `OFS_SLAVE_MASK) begin
        slave_address_mask_q <= pwdata_in[7:0];
      end
    end
  end

  // both done flags share one request, gated by both enables
  assign irq_out = (rx_done_flag_q | tx_done_flag_q) & uart_irq_enable_q & global_irq_enable_q;

  // oversample divider: 16 ticks per async bit, 6 clocks per shift bit
  always_comb begin
    if (mode == MODE_9FIX) begin
      div_max = baud_doubler_q ? 10'h000 : 10'h001;
    end else if (is_shift) begin
      div_max = 10'h000;
    end else begin
      div_max = baud_doubler_q ? (`RELOAD_TOP - {2'b00, reload_q} - 10'h001)
                        : (((`RELOAD_TOP - {2'b00, reload_q}) << 1) - 10'h001);
    end
  end

  assign os_tick = (div_cnt_q >= div_max);

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      div_cnt_q <= 10'h000;
    end else begin
      div_cnt_q <= os_tick ? 10'h000 : div_cnt_q + 10'h001;
    end
  end

  // two-flop synchroniser on the receive pin, then an edge history flop
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      {rxd_m_q, rxd_s_q, rxd_p_q} <= 3'b111; // idle line level, so no false start edge
    end else begin
      rxd_m_q <= rxd_in;
      rxd_s_q <= rxd_m_q;
      rxd_p_q <= rxd_s_q;
    end
  end

  // address recognition: given and broadcast forms
  assign bcast     = slave_individual_address_q | slave_address_mask_q;
  assign given_hit = ((rx_byte ^ slave_individual_address_q) & slave_address_mask_q) == 8'h00;
  assign bcast_hit = ((rx_byte ^ bcast) & bcast) == 8'h00;
  assign mp_active = multiproc_enable_q & ~is_shift;

  // sample point, bit indices and frame decision
  assign rx_sample   = (rx_state_q == LINE_BUSY) & os_tick & (rx_cnt_q == tick_sample);
  assign rx_stop_idx = (mode == MODE_8BIT) ? 4'h9 : 4'hA;
  // eight-bit mode decides on the stop bit since it serves as ninth bit
  assign rx_eval_idx = is_shift ? 4'h7 : ((mode == MODE_8BIT || framing_detect_enable_q) ? rx_stop_idx : 4'h9);
  assign rx_last     = rx_sample & (rx_bit_q == (is_shift ? 4'h7 : rx_stop_idx));
  assign rx_eval     = rx_sample & (rx_bit_q == rx_eval_idx);
  assign rx_byte     = is_shift ? {rxd_s_q, rx_sh_q[7:1]} : rx_sh_q;
  assign rx_ninth    = (rx_bit_q == 4'hA) ? rx_ninth_q : rxd_s_q;
  // ninth bit zero is dropped when multiproc is on, kept when off
  assign rx_accept   = rx_eval & (~mp_active | (rx_ninth & (given_hit | bcast_hit)));
  assign rx_fe_set   = rx_sample & ~is_shift & framing_detect_enable_q & (rx_bit_q == rx_stop_idx) & ~rxd_s_q;

  // receiver sequencer
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      rx_state_q <= LINE_IDLE;
      rx_cnt_q   <= 4'h0;
      rx_bit_q   <= 4'h0;
      rx_sh_q    <= 8'h00;
      rx_ninth_q <= 1'b0;
    end else begin
      case (rx_state_q)
        LINE_IDLE: begin
          rx_cnt_q <= 4'h0;
          rx_bit_q <= 4'h0;
          // shift mode clocks a byte in while enabled, flag clear and transmitter idle
          if (ren_q && ((is_shift && !rx_done_flag_q && tx_state_q == LINE_IDLE) ||
                        (!is_shift && rxd_p_q && !rxd_s_q))) begin
            rx_state_q <= LINE_BUSY;
          end
        end
        LINE_BUSY: begin
          if (!ren_q) begin
            rx_state_q <= LINE_IDLE;
          end else if (os_tick) begin
            rx_cnt_q <= (rx_cnt_q == tick_last) ? 4'h0 : rx_cnt_q + 4'h1;
            if (rx_cnt_q == tick_last) begin
              rx_bit_q <= rx_bit_q + 4'h1;
            end
            if (rx_sample) begin
              if (!is_shift && rx_bit_q == 4'h0 && rxd_s_q) begin
                rx_state_q <= LINE_IDLE; // glitch, not a start bit
              end else if (is_shift || (rx_bit_q >= 4'h1 && rx_bit_q <= 4'h8)) begin
                rx_sh_q <= {rxd_s_q, rx_sh_q[7:1]};
              end else if (rx_bit_q == 4'h9) begin
                rx_ninth_q <= rxd_s_q;
              end
              if (rx_last) begin
                rx_state_q <= LINE_IDLE;
              end
            end
          end
        end
        default: begin
          rx_state_q <= LINE_IDLE;
        end
      endcase
    end
  end

  // received byte kept only for accepted frames
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      rx_data_q <= `RST_BYTE;
    end else if (rx_accept) begin
      rx_data_q <= rx_byte;
    end
  end

  // transmit frame lengths: TI rises at the end of the last data bit
  assign tx_last_idx = is_shift ? 4'h7 : ((mode == MODE_8BIT) ? 4'h9 : 4'hA);
  assign tx_done_idx = is_shift ? 4'h7 : ((mode == MODE_8BIT) ? 4'h8 : 4'h9);
  assign tx_end_bit  = (tx_state_q == LINE_BUSY) & os_tick & (tx_cnt_q == tick_last);
  assign tx_set      = tx_end_bit & (tx_bit_q == tx_done_idx);

  // transmitter; a write while busy is dropped
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      tx_state_q <= LINE_IDLE;
      tx_cnt_q   <= 4'h0;
      tx_bit_q   <= 4'h0;
      tx_sh_q    <= 11'h7FF;
    end else begin
      case (tx_state_q)
        LINE_IDLE: begin
          tx_cnt_q <= 4'h0;
          tx_bit_q <= 4'h0;
          if (wr_data) begin
            tx_state_q <= LINE_BUSY;
            if (is_shift) begin
              tx_sh_q <= {3'h7, pwdata_in[7:0]};
            end else if (mode == MODE_8BIT) begin
              tx_sh_q <= {2'h3, pwdata_in[7:0], 1'b0};
            end else begin
              tx_sh_q <= {1'b1, tx_ninth_bit_q, pwdata_in[7:0], 1'b0};
            end
          end
        end
        LINE_BUSY: begin
          if (os_tick) begin
            tx_cnt_q <= (tx_cnt_q == tick_last) ? 4'h0 : tx_cnt_q + 4'h1;
          end
          if (tx_end_bit) begin
            tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q == tx_last_idx) begin
              tx_state_q <= LINE_IDLE;
            end
          end
        end
        default: begin
          tx_state_q <= LINE_IDLE;
        end
      endcase
    end
  end

  // registered pins; shift mode drives data on rxd and clock on txd
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      {txd_out, rxd_out, rxd_oe_out} <= 3'b110;
    end else if (is_shift) begin
      txd_out    <= ~((tx_state_q == LINE_BUSY || rx_state_q == LINE_BUSY) && tx_cnt_q <= tick_sample &&
                      rx_cnt_q <= tick_sample);
      rxd_out    <= tx_sh_q[0];
      rxd_oe_out <= (tx_state_q == LINE_BUSY);
    end else begin
      txd_out    <= (tx_state_q == LINE_BUSY) ? tx_sh_q[0] : 1'b1;
      rxd_out    <= 1'b1;
      rxd_oe_out <= 1'b0;
    end
  end

endmodule : uart_multiproc_address_recog

// ==== uart_mp_checker_sva.sv ====
// assertion checker for the serial port bus and line pins
`timescale 1ns/1ps
`include "uart_mp_consts.svh"

module uart_mp_checker
  import uart_mp_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys_in,
  input wire logic        rst_b_in,
  // apb
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // line and request
  input wire logic        rxd_in,
  input wire logic        rxd_out,
  input wire logic        rxd_oe_out,
  input wire logic        txd_out,
  input wire logic        irq_out
);
  logic [7:0] ie_q, pc_q, ad_q, mk_q, low_q, sh_w;
  logic [1:0] md_q;
  logic       wr_w, map_w, hit_w;

  // decode of the access phase
  assign wr_w  = psel_in & penable_in & pwrite_in;
  assign hit_w = paddr_in inside {`OFS_IRQ_ENABLE_REG, `OFS_POWER_CONTROL, `OFS_SLAVE_ADDR, `OFS_SLAVE_MASK};
  assign map_w = hit_w | (paddr_in inside {`OFS_SERIAL_CONTROL, `OFS_SERIAL_DATA, `OFS_BAUD_RELOAD});

  // mirrors of registers only software changes; bit 7 is the error flag while detect is on
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      {ie_q, pc_q, ad_q, mk_q} <= 32'h00000000;
      md_q <= 2'b00;
    end else if (wr_w) begin
      if (paddr_in == `OFS_IRQ_ENABLE_REG) ie_q <= pwdata_in[7:0];
      if (paddr_in == `OFS_POWER_CONTROL) pc_q <= pwdata_in[7:0];
      if (paddr_in == `OFS_SLAVE_ADDR) ad_q <= pwdata_in[7:0];
      if (paddr_in == `OFS_SLAVE_MASK) mk_q <= pwdata_in[7:0];
      if (paddr_in == `OFS_SERIAL_CONTROL) md_q <= {pc_q[`PC_FRAMING_DETECT] ? md_q[1] : pwdata_in[7], pwdata_in[6]};
    end
  end

  // mirror value for the address being read
  always_comb begin
    case (paddr_in)
      `OFS_IRQ_ENABLE_REG: sh_w = ie_q;
      `OFS_POWER_CONTROL:  sh_w = pc_q;
      `OFS_SLAVE_ADDR:     sh_w = ad_q;
      default:             sh_w = mk_q;
    endcase
  end

  // run of low samples on the transmit line, saturating
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in || txd_out) low_q <= 8'h00;
    else if (low_q != 8'hFF) low_q <= low_q + 8'h01;
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_acc; psel_in && penable_in; endsequence
  sequence s_rd; psel_in && penable_in && !pwrite_in; endsequence

  bit_time_a:
    assert property ($rose(txd_out) && md_q == MODE_9FIX |->
      low_q != 8'h00 && (pc_q[7] ? low_q[3:0] == 4'h0 : low_q[4:0] == 5'h00))
      else $error("transmit low run not whole bits");
  irq_gate_a:
    assert property (irq_out |-> ie_q[`IE_UART] && ie_q[`IE_GLOBAL]) else $error("request without enables");
  irq_hold_a:
    assert property (irq_out && !wr_w |=> irq_out) else $error("request dropped without software");
  readback_a:
    assert property (s_rd ##0 hit_w |-> prdata_out == {24'h000000, sh_w}) else $error("register readback wrong");
  shift_drive_a:
    assert property (rxd_oe_out |-> md_q == MODE_SHIFT) else $error("data pin driven outside shift mode");
  unmapped_err_a:
    assert property (s_rd ##0 !map_w |-> pslverr_out && prdata_out == 32'h00000000) else $error("unmapped read");
  mapped_ok_a:
    assert property (s_acc ##0 map_w |-> pready_out && !pslverr_out) else $error("mapped access refused");
  upper_zero_a:
    assert property (s_rd |-> prdata_out[31:8] == 24'h000000) else $error("upper read bits set");
endmodule : uart_mp_checker

bind uart_multiproc_address_recog uart_mp_checker checker_i (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .rxd_in(rxd_in),
  .rxd_out(rxd_out), .rxd_oe_out(rxd_oe_out), .txd_out(txd_out), .irq_out(irq_out));

// ==== uart_peer_model.sv ====
// behavioural remote serial node: sends frames, decodes frames from the port
`timescale 1ns/1ps

module uart_peer_model (
  // clock
  input  wire logic       clk_in,
  // line from the port and decode enable
  input  wire logic       txd_in,
  input  wire logic       listen_in,
  // line to the port
  output logic            line_out,
  // decoded frame: stop, ninth, data
  output logic [9:0]      frame_out,
  output logic            frame_stb_out
);
  int bit_clks = 16;

  // released line rests at its pull-up level
  initial begin
    line_out = 1'b1;
    frame_out = 10'h000;
    frame_stb_out = 1'b0;
  end

  // start, data lsb first, optional ninth bit, stop
  task automatic send(input logic [7:0] d, input logic n9, input logic nine, input logic stop);
    logic [10:0] f;
    f = nine ? {stop, n9, d, 1'b0} : {1'b1, stop, d, 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      line_out <= f[i];
      repeat (bit_clks) @(posedge clk_in);
    end
    line_out <= 1'b1;
  endtask : send

  // mid-bit sampling; only while told to listen, the shift clock would look like frames
  always begin
    @(posedge clk_in iff (listen_in && txd_in === 1'b0));
    repeat (bit_clks / 2) @(posedge clk_in);
    for (int i = 0; i < 10; i++) begin
      repeat (bit_clks) @(posedge clk_in);
      frame_out[i] <= txd_in;
    end
    frame_stb_out <= 1'b1;
    @(posedge clk_in);
    frame_stb_out <= 1'b0;
  end
endmodule : uart_peer_model

// ==== uart_multiproc_address_recog_tb_top.sv ====
// self-checking bench for the multiprocessor serial port
`timescale 1ns/1ps
`include "uart_mp_consts.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end

module uart_multiproc_address_recog_tb_top;
  logic        clk_sys_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h00000000;
  logic [31:0] prdata_out;
  logic        pready_out, pslverr_out, rxd_out, rxd_oe_out, txd_out, irq_out;
  logic        line_w, rxd_w, stb_w, listen_q = 1'b0;
  logic [9:0]  frame_w, f;
  logic [15:0] n;
  logic [7:0]  sc, b, last_b, sh_q;
  logic [15:0] e_q [$];
  logic [9:0]  t_q [$];
  int          error_cnt = 0;
  int          checks = 0;
  int          seed = 32'hc226;

  always #12.5 clk_sys_in = ~clk_sys_in;
  // data pin is the port's while it drives, else the peer's line
  assign rxd_w = rxd_oe_out ? rxd_out : line_w;

  // shift-mode data pin, taken as the shift clock rises mid-bit
  always @(posedge txd_out) begin
    if (rxd_oe_out === 1'b1) sh_q <= {rxd_out, sh_q[7:1]};
  end

  uart_multiproc_address_recog uart_multiproc_address_recog_i (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .rxd_in(rxd_w),
    .rxd_out(rxd_out), .rxd_oe_out(rxd_oe_out), .txd_out(txd_out), .irq_out(irq_out));
  uart_peer_model uart_peer_model_i (.clk_in(clk_sys_in), .txd_in(txd_out), .listen_in(listen_q),
    .line_out(line_w), .frame_out(frame_w), .frame_stb_out(stb_w));

  // one apb transfer; a read leaves mask and expected byte for the monitor
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [7:0] m);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= {24'h000000, d};
    if (!w) e_q.push_back({m, d});
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do @(posedge clk_sys_in); while (pready_out !== 1'b1);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask : apb

  // given or broadcast pattern, zero bits ignored
  function automatic logic mp_match(input logic [7:0] d, input logic [7:0] a, input logic [7:0] m);
    return (((d ^ a) & m) == 8'h00) || (((d ^ (a | m)) & (a | m)) == 8'h00);
  endfunction : mp_match

  // peer frame, then flags and data checked and the receive flag cleared
  task automatic rx_case(input logic [7:0] d, input logic n9, input logic nine, input logic acc);
    uart_peer_model_i.send(d, n9, nine, n9 | nine);
    repeat (4) @(posedge clk_sys_in);
    if (acc) last_b = d;
    apb(1'b0, `OFS_SERIAL_CONTROL, {5'h00, n9 & acc, 1'b0, acc}, acc ? 8'h05 : 8'h01);
    apb(1'b0, `OFS_SERIAL_DATA, last_b, 8'hFF);
    apb(1'b1, `OFS_SERIAL_CONTROL, sc, 8'h00);
  endtask : rx_case

  task automatic summarize;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // each read and each decoded frame against the oldest note
  always @(posedge clk_sys_in) begin
    if (psel_in && penable_in && !pwrite_in && pready_out) begin
      n = e_q.pop_front();
      `CHK({prdata_out[31:8], prdata_out[7:0] & n[15:8]}, {24'h000000, n[7:0] & n[15:8]})
    end
    if (stb_w) begin
      f = t_q.pop_front();
      `CHK(frame_w, f)
    end
  end

  // cuts a hang short
  initial begin
    repeat (10000) @(posedge clk_sys_in);
    error_cnt++;
    summarize();
  end

  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    @(posedge clk_sys_in);
    apb(1'b0, `OFS_SERIAL_CONTROL, 8'h00, 8'hFF);
    apb(1'b0, `OFS_SLAVE_ADDR, 8'h00, 8'hFF);
    apb(1'b0, `OFS_SLAVE_MASK, 8'h00, 8'hFF);
    apb(1'b0, 12'h0FC, 8'h00, 8'hFF);
    // shift mode: send a byte, then receive with multiproc set
    apb(1'b1, `OFS_SERIAL_DATA, 8'hA5, 8'h00);
    repeat (60) @(posedge clk_sys_in);
    `CHK(sh_q, 8'hA5)
    apb(1'b0, `OFS_SERIAL_CONTROL, 8'h02, 8'h02);
    apb(1'b1, `OFS_SERIAL_CONTROL, 8'h30, 8'h00);
    repeat (60) @(posedge clk_sys_in);
    last_b = 8'hFF;
    apb(1'b0, `OFS_SERIAL_CONTROL, 8'h01, 8'h01);
    apb(1'b0, `OFS_SERIAL_DATA, last_b, 8'hFF);
    apb(1'b1, `OFS_SERIAL_CONTROL, 8'h00, 8'h00);
    // fixed nine-bit mode transmit, both ninth-bit values
    apb(1'b1, `OFS_POWER_CONTROL, 8'h80, 8'h00);
    listen_q <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      sc = {4'h8, i[0], 3'h0};
      b = 8'($random(seed));
      apb(1'b1, `OFS_SERIAL_CONTROL, sc, 8'h00);
      t_q.push_back({1'b1, i[0], b});
      apb(1'b1, `OFS_SERIAL_DATA, b, 8'h00);
      repeat (200) @(posedge clk_sys_in);
      apb(1'b0, `OFS_SERIAL_CONTROL, 8'h02, 8'h02);
    end
    listen_q <= 1'b0;
    // merged request with both enables, then global enable cleared, then flag cleared
    apb(1'b1, `OFS_IRQ_ENABLE_REG, 8'h90, 8'h00);
    `CHK(irq_out, 1'b1)
    apb(1'b1, `OFS_IRQ_ENABLE_REG, 8'h10, 8'h00);
    `CHK(irq_out, 1'b0)
    apb(1'b1, `OFS_IRQ_ENABLE_REG, 8'h90, 8'h00);
    apb(1'b1, `OFS_SERIAL_CONTROL, sc, 8'h00);
    `CHK(irq_out, 1'b0)
    // address recognition, reset pattern first
    sc = 8'hB0;
    apb(1'b1, `OFS_SERIAL_CONTROL, sc, 8'h00);
    rx_case(8'h13, 1'b1, 1'b1, 1'b1);
    apb(1'b1, `OFS_SLAVE_ADDR, 8'h56, 8'h00);
    apb(1'b1, `OFS_SLAVE_MASK, 8'hFC, 8'h00);
    rx_case(8'h55, 1'b1, 1'b1, 1'b1);
    rx_case(8'h56, 1'b0, 1'b1, 1'b0);
    rx_case(8'hFF, 1'b1, 1'b1, 1'b1);
    rx_case(8'h13, 1'b1, 1'b1, 1'b0);
    b = 8'($random(seed));
    rx_case(b, 1'b1, 1'b1, mp_match(b, 8'h56, 8'hFC));
    sc = 8'h90;
    apb(1'b1, `OFS_SERIAL_CONTROL, sc, 8'h00);
    rx_case(8'h13, 1'b0, 1'b1, 1'b1);
    // eight-bit mode: stop bit stands in for the ninth
    apb(1'b1, `OFS_BAUD_RELOAD, 8'hFF, 8'h00);
    sc = 8'h70;
    apb(1'b1, `OFS_SERIAL_CONTROL, sc, 8'h00);
    rx_case(8'h55, 1'b1, 1'b0, 1'b1);
    rx_case(8'h55, 1'b0, 1'b0, 1'b0);
    // framing error stays set over a good frame
    sc = 8'h90;
    apb(1'b1, `OFS_SERIAL_CONTROL, sc, 8'h00);
    apb(1'b1, `OFS_POWER_CONTROL, 8'hC0, 8'h00);
    uart_peer_model_i.send(8'h12, 1'b0, 1'b1, 1'b0);
    repeat (4) @(posedge clk_sys_in);
    apb(1'b0, `OFS_SERIAL_CONTROL, 8'h80, 8'h80);
    apb(1'b1, `OFS_SERIAL_CONTROL, sc, 8'h00);
    uart_peer_model_i.send(8'h12, 1'b0, 1'b1, 1'b1);
    repeat (4) @(posedge clk_sys_in);
    apb(1'b0, `OFS_SERIAL_CONTROL, 8'h81, 8'h81);
    summarize();
  end
endmodule : uart_multiproc_address_recog_tb_top
